// ---- bench/iopcb_pins_model.sv ----
/*
  Far-side pin model: drives pins the bank releases, resolving each wire.
  Assumes the bench sets which pins are driven from outside and their levels.
*/
`timescale 1ns/100ps
module iopcb_pins_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] pin_out_in,
  input  wire logic [31:0] pin_oe_in,
  input  wire logic [31:0] pull_in,
  input  wire logic [31:0] ext_val_in,
  input  wire logic [31:0] ext_en_in,
  output logic      [31:0] pin_level_out
);
  logic [31:0] float_q = 32'h0;
  // Undriven, unpulled wires wander every cycle
  always_ff @(posedge clk_in) float_q <= ~float_q;
  always_comb
    for (int i = 0; i < 32; i++)
      pin_level_out[i] = pin_oe_in[i] ? pin_out_in[i] : ext_en_in[i] ? ext_val_in[i] : pull_in[i] ? 1'b0 : float_q[i];
endmodule : iopcb_pins_model

// ---- bench/iopcb_port_bank_chk.sv ----
/*
  Concurrent checks on the port bank's ports.
  Assumes one clock domain and block 0 ticking every enabled clock.
*/
`timescale 1ns/100ps
module iopcb_port_bank_chk (
  input wire logic                              clk_in,
  input wire logic                              rst_n_in,
  input wire logic                              clk_en_in,
  input wire iopcb_pkg::iopcb_port_cfg_t        wide_cfg_in,
  input wire iopcb_pkg::iopcb_port_cfg_t        narrow_cfg_in,
  input wire logic                              link_en_in,
  input wire logic                              in_valid_out,
  input wire logic                              in_take_in,
  input wire logic [iopcb_pkg::WIDE_WIDTH-1:0]  in_data_out,
  input wire logic [iopcb_pkg::COUNT_WIDTH-1:0] in_stamp_out,
  input wire logic [iopcb_pkg::COUNT_WIDTH-1:0] count_out,
  input wire logic                              narrow_data_in,
  input wire logic                              strobe_out,
  input wire logic [iopcb_pkg::BANK_PINS-1:0]   pin_out,
  input wire logic [iopcb_pkg::BANK_PINS-1:0]   pin_oe_out,
  input wire logic [iopcb_pkg::BANK_PINS-1:0]   pull_down_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_held;
    in_valid_out && !in_take_in && clk_en_in;
  endsequence
  sequence s_narrow_drive;
    clk_en_in && narrow_cfg_in.enable && narrow_cfg_in.drive && !narrow_cfg_in.open_col && narrow_cfg_in.clk_sel == 3'h0;
  endsequence
  chk_reset_pull_down: assert property (disable iff (1'b0) !rst_n_in |-> pull_down_out == iopcb_pkg::PULL_ALL_ON)
    else $error("pull-downs not all on in reset");
  chk_link_pins_free: assert property (link_en_in && $past(link_en_in) |-> pin_oe_out[31:24] == 8'h0)
    else $error("port drives a link pin");
  chk_count_step: assert property (clk_en_in && $past(clk_en_in) && $past(clk_en_in, 2) && $past(clk_en_in, 3)
    && $past(rst_n_in) && $past(rst_n_in, 2) && $past(wide_cfg_in.clk_sel, 3) == 3'h0
    |-> count_out == $past(count_out) + 16'h0001) else $error("counter did not step by one");
  chk_strobe_out_gate: assert property (strobe_out |-> $past(wide_cfg_in.strobe_out_en))
    else $error("strobe while disabled");
  chk_open_col_low: assert property (strobe_out && $past(wide_cfg_in.open_col) |-> pin_out[23:1] == 23'h0)
    else $error("open collector drives high");
  chk_in_word_held: assert property (s_held |=> in_valid_out && $stable(in_data_out) && $stable(in_stamp_out))
    else $error("untaken input word lost");
  chk_in_stamp_count: assert property ($rose(in_valid_out) |-> in_stamp_out == count_out)
    else $error("timestamp differs from counter");
  chk_narrow_wins_pin: assert property (s_narrow_drive [*3] |=> pin_oe_out[0] && pin_out[0] == $past(narrow_data_in, 2))
    else $error("narrow port lost pin 0");
endmodule : iopcb_port_bank_chk

bind iopcb_port_bank iopcb_port_bank_chk iopcb_port_bank_chk_i (.clk_in, .rst_n_in, .clk_en_in, .wide_cfg_in,
  .narrow_cfg_in, .link_en_in, .in_valid_out, .in_take_in, .in_data_out, .in_stamp_out, .count_out,
  .narrow_data_in, .strobe_out, .pin_out, .pin_oe_out, .pull_down_out);

// ---- bench/iopcb_port_bank_tb_top.sv ----
/*
  Self-checking bench for the port bank with an output FIFO model.
  Assumes the pin model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module iopcb_port_bank_tb_top;
  logic        clk_in = 1'b0, rst_n_in = 1'b1, clk_en_in = 1'b1, link_en_in = 1'b0, out_valid_in = 1'b0;
  logic        in_take_in = 1'b0, narrow_data_in = 1'b0, strobe_in = 1'b0;
  logic        out_ready_out, in_valid_out, narrow_value_out, strobe_out;
  logic [31:0] in_data_out, pin_in, pin_out, pin_oe_out, pull_down_out, v, msk, ext_val = 32'h0, ext_en = 32'h0;
  logic [15:0] in_stamp_out, out_stamp_out, count_out, c;
  logic [6:0]  hit = 7'h0a, exp_v = 7'h53;
  int          fail_count = 0, check_count = 0, seed = 32'hc9881b67;
  iopcb_pkg::iopcb_port_cfg_t     wide_cfg_in = '{enable: 1'b1, strobe_out_en: 1'b1, cond: iopcb_pkg::IOPCB_COND_NONE, default: '0};
  iopcb_pkg::iopcb_port_cfg_t     narrow_cfg_in = '0;
  iopcb_pkg::iopcb_cb_cfg_t [1:5] cb_cfg_in = '0;
  iopcb_pkg::iopcb_out_word_t     out_word_in = '0, w;
  iopcb_pkg::iopcb_out_word_t     exp_q[$];
  iopcb_pkg::iopcb_cond_t         cnd[7] = '{iopcb_pkg::IOPCB_COND_NONE, iopcb_pkg::IOPCB_COND_EQ, iopcb_pkg::IOPCB_COND_EQ,
    iopcb_pkg::IOPCB_COND_NE, iopcb_pkg::IOPCB_COND_NE, iopcb_pkg::IOPCB_COND_NONE, iopcb_pkg::IOPCB_COND_NONE};

  initial forever #10 clk_in = ~clk_in;

  iopcb_port_bank iopcb_port_bank_i (.clk_in, .rst_n_in, .clk_en_in, .wide_cfg_in, .narrow_cfg_in, .cb_cfg_in,
    .link_en_in, .out_valid_in, .out_ready_out, .out_word_in, .in_valid_out, .in_take_in, .in_data_out,
    .in_stamp_out, .out_stamp_out, .count_out, .narrow_data_in, .narrow_value_out, .strobe_in, .strobe_out,
    .pin_in, .pin_out, .pin_oe_out, .pull_down_out);
  iopcb_pins_model iopcb_pins_model_i (.clk_in, .pin_out_in(pin_out), .pin_oe_in(pin_oe_out),
    .pull_in(pull_down_out), .ext_val_in(ext_val), .ext_en_in(ext_en), .pin_level_out(pin_in));

  // Output word model: each strobe retires the oldest accepted word
  always begin
    @(posedge clk_in);
    #2;
    if (strobe_out === 1'b1) begin
      `CHK("fifo_word", 1'b1, exp_q.size() > 0)
      if (exp_q.size() > 0) begin
        w = exp_q.pop_front();
        msk = link_en_in ? 32'h00ffffff : 32'hffffffff;
        `CHK("pin_oe", (wide_cfg_in.open_col ? ~w.data : 32'hffffffff) & msk, pin_oe_out & msk)
        `CHK("pin_out", (wide_cfg_in.open_col ? 32'h0 : w.data) & msk, pin_out & msk)
        if (w.timed) `CHK("out_stamp", w.when, out_stamp_out)
      end
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick

  // Leaves the offer raised; caller lowers it or pushes again
  task automatic push(input logic tm, input logic [15:0] wh);
    out_word_in = '{data: $random(seed), timed: tm, when: wh};
    out_valid_in = 1'b1;
    while (out_ready_out !== 1'b1) tick(1);
    exp_q.push_back(out_word_in);
    tick(1);
  endtask : push

  task automatic print_verdict;
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end

  initial begin
    #1 rst_n_in = 1'b0;
    tick(3);
    `CHK("pull_rst", iopcb_pkg::PULL_ALL_ON, pull_down_out)
    `CHK("oe_rst", 32'h0, pin_oe_out)
    rst_n_in = 1'b1;
    tick(2);
    `CHK("pull_run", 32'h0, pull_down_out)
    c = count_out;
    tick(10);
    `CHK("count_run", c + 16'h000a, count_out)
    clk_en_in = 1'b0;
    c = count_out;
    tick(5);
    `CHK("count_frozen", c, count_out)
    clk_en_in = 1'b1;
    cb_cfg_in[1].divide = 8'h03;
    wide_cfg_in.clk_sel = 3'h1;
    tick(2);
    c = count_out;
    tick(40);
    `CHK("count_div", c + 16'h000a, count_out)
    ext_en = 32'hffffffff;
    cb_cfg_in[2].from_pin = 1'b1;
    wide_cfg_in.clk_sel = 3'h2;
    tick(4);
    c = count_out;
    repeat (5) begin
      ext_val[0] = 1'b1;
      tick(2);
      ext_val[0] = 1'b0;
      tick(2);
    end
    tick(4);
    `CHK("count_pin", c + 16'h0005, count_out)
    wide_cfg_in.clk_sel = 3'h0;
    for (int k = 0; k < 7; k++) begin
      wide_cfg_in.enable = 1'b0;
      tick(1);
      in_take_in = 1'b1;
      tick(1);
      in_take_in = 1'b0;
      v = $random(seed);
      ext_val = v;
      wide_cfg_in.cond = cnd[k];
      wide_cfg_in.cond_value = hit[k] ? v : ~v;
      wide_cfg_in.strobe_in_en = k > 4;
      strobe_in = k == 6;
      wide_cfg_in.enable = 1'b1;
      tick(4);
      `CHK("in_valid", exp_v[k], in_valid_out)
      if (exp_v[k]) `CHK("in_data", v, in_data_out)
      ext_val = ~v;
      tick(2);
      if (exp_v[k]) `CHK("in_held", v, in_data_out)
    end
    ext_en = 32'h0;
    wide_cfg_in.drive = 1'b1;
    wide_cfg_in.clk_sel = 3'h7;
    push(1'b0, 16'h0);
    push(1'b0, 16'h0);
    `CHK("refused", 1'b0, out_ready_out)
    out_valid_in = 1'b0;
    wide_cfg_in.clk_sel = 3'h0;
    tick(8);
    `CHK("drained", 0, exp_q.size())
    c = count_out;
    push(1'b1, c + 16'h001e);
    out_valid_in = 1'b0;
    tick(40);
    `CHK("timed_done", 0, exp_q.size())
    wide_cfg_in.open_col = 1'b1;
    link_en_in = 1'b1;
    push(1'b0, 16'h0);
    push(1'b0, 16'h0);
    out_valid_in = 1'b0;
    tick(6);
    `CHK("oc_done", 0, exp_q.size())
    narrow_cfg_in.enable = 1'b1;
    narrow_cfg_in.drive = 1'b1;
    repeat (6) begin
      narrow_data_in = 1'($random(seed));
      tick(1);
    end
    narrow_cfg_in.drive = 1'b0;
    ext_en = 32'h00000001;
    ext_val[0] = ~narrow_data_in;
    tick(3);
    `CHK("narrow_in", ~narrow_data_in, narrow_value_out)
    rst_n_in = 1'b0;
    tick(1);
    `CHK("pull_rst2", iopcb_pkg::PULL_ALL_ON, pull_down_out)
    `CHK("count_rst", 16'h0, count_out)
    rst_n_in = 1'b1;
    tick(2);
    `CHK("pull_run2", 32'h0, pull_down_out)
    print_verdict();
  end
endmodule : iopcb_port_bank_tb_top

// ---- rtl/iopcb_buf2.sv ----
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock, asynchronous active-low reset and a freezing clock enable.
*/
`timescale 1ns/100ps
module iopcb_buf2 #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             clk_en_in,
  input  wire logic             s_valid_in,
  output logic                  s_ready_out,
  input  wire logic [WIDTH-1:0] s_data_in,
  output logic                  m_valid_out,
  input  wire logic             m_ready_in,
  output logic      [WIDTH-1:0] m_data_out
);

  logic [WIDTH-1:0] mem_q [0:iopcb_pkg::BUF_DEPTH-1];
  logic             wr_ptr_q;
  logic             rd_ptr_q;
  logic             full_q;
  logic             empty_q;
  logic             push;
  logic             pop;

  assign push        = s_valid_in && !full_q;
  assign pop         = m_ready_in && !empty_q;
  assign s_ready_out = !full_q;
  assign m_valid_out = !empty_q;
  assign m_data_out  = mem_q[rd_ptr_q];

  always_ff @(posedge clk_in) begin
    if (clk_en_in && push) begin
      mem_q[wr_ptr_q] <= s_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      full_q   <= 1'b0;
      empty_q  <= 1'b1;
    end else if (clk_en_in) begin
      if (push) begin
        wr_ptr_q <= !wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= !rd_ptr_q;
      end
      if (push && !pop) begin
        empty_q <= 1'b0;
        full_q  <= (wr_ptr_q != rd_ptr_q) || !empty_q;
      end else if (pop && !push) begin
        full_q  <= 1'b0;
        empty_q <= (wr_ptr_q == !rd_ptr_q);
      end
    end
  end

endmodule : iopcb_buf2

// ---- rtl/iopcb_pkg.sv ----
/*
  Shared constants, carrier structs and enumerations for the I/O port bank
  with clock blocks. Assumes one 50 MHz tile clock drives every user.
*/
package iopcb_pkg;

  localparam int unsigned BANK_PINS    = 32;
  localparam int unsigned WIDE_WIDTH   = 32;
  localparam int unsigned NARROW_WIDTH = 1;
  localparam int unsigned COUNT_WIDTH  = 16;
  localparam int unsigned NUM_CB       = 6;
  localparam int unsigned CB_SEL_WIDTH = 3;
  localparam int unsigned DIV_WIDTH    = 8;

  // Pin positions
  localparam int unsigned NARROW_PIN   = 0;
  localparam int unsigned CLK_SRC_PIN  = 0;
  localparam int unsigned LINK_LO_PIN  = 24;
  localparam int unsigned LINK_HI_PIN  = 31;

  // Reset, run and step values
  localparam logic [CB_SEL_WIDTH-1:0] CB_REF       = 3'h0;
  localparam logic [BANK_PINS-1:0]    PULL_ALL_ON  = 32'hffffffff;
  localparam logic [BANK_PINS-1:0]    PULL_ALL_OFF = 32'h00000000;
  localparam logic [COUNT_WIDTH-1:0]  COUNT_RESET  = 16'h0000;
  localparam logic [COUNT_WIDTH-1:0]  COUNT_STEP   = 16'h0001;
  localparam logic [DIV_WIDTH-1:0]    DIV_RESET    = 8'h00;
  localparam logic [DIV_WIDTH-1:0]    DIV_STEP     = 8'h01;

  // Timing: clock block 0 ticks on every tile clock edge
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned REF_PERIOD_NS   = 20;
  localparam int unsigned REF_TICK_CYCLES = REF_PERIOD_NS / CLK_PERIOD_NS;

  localparam int unsigned BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    IOPCB_COND_NONE = 2'b00,
    IOPCB_COND_EQ   = 2'b01,
    IOPCB_COND_NE   = 2'b11
  } iopcb_cond_t;

  typedef struct packed {
    logic                   from_pin;
    logic [DIV_WIDTH-1:0]   divide;
  } iopcb_cb_cfg_t;

  typedef struct packed {
    logic                    enable;
    logic                    drive;
    logic                    open_col;
    logic [CB_SEL_WIDTH-1:0] clk_sel;
    iopcb_cond_t             cond;
    logic [WIDE_WIDTH-1:0]   cond_value;
    logic                    strobe_in_en;
    logic                    strobe_out_en;
  } iopcb_port_cfg_t;

  typedef struct packed {
    logic [WIDE_WIDTH-1:0]  data;
    logic                   timed;
    logic [COUNT_WIDTH-1:0] when;
  } iopcb_out_word_t;

  localparam int unsigned OUT_WORD_BITS = $bits(iopcb_out_word_t);

endpackage : iopcb_pkg

// ---- rtl/iopcb_port_bank.sv ----
/*
  I/O port bank: one 32-bit port and one 1-bit port on 32 shared pins,
  a 16-bit port counter, timed and conditional transfers, strobes and six
  clock blocks. Assumes core requests are synchronous to clk_in and that
  pins are sampled directly as synchronous inputs.
*/
`timescale 1ns/100ps

// Function
// - Ports come in widths 1, 4, 8, 16, 32; here one 32-bit and one 1-bit.
// - All pins of one port share a single direction.
// - A port drives its pins or samples them, optionally awaiting a condition; here only the wide port awaits one.
// - Every core access to a port completes in one cycle; here a wide port write waits while out_ready_out is low with its buffer full.
// - Open-collector mode drives low for zero, releases for one, per port.
// - Data passes through a per-port buffer and transfer register; here only the wide port's output path has a buffer.
// - A 16-bit port counter can schedule when data moves to the pins.
// - The core can read the port counter at any time.
// - Each transfer captures the counter value as a readable timestamp; here only the wide port captures one.
// - An enabled link disables port use of its shared pins; here only driving stops, the wide port still samples them.
// - Enabled narrower port overrides wider on shared pins; others stay usable.
// - Each port always transfers at its own full width.
// - Six clock blocks; block 0 is the reference, others set independently.
// - A clock block may take a 1-bit port as source and divide it.
// - Ports accept an input strobe and can generate an output strobe; here only the wide port has strobes.
// - After reset every port uses clock block 0.
// - While reset is low every pin has its pull-down on.
module iopcb_port_bank (
  input  wire logic                                   clk_in,
  input  wire logic                                   rst_n_in,
  input  wire logic                                   clk_en_in,
  // Configuration
  input  wire iopcb_pkg::iopcb_port_cfg_t             wide_cfg_in,
  input  wire iopcb_pkg::iopcb_port_cfg_t             narrow_cfg_in,
  input  wire iopcb_pkg::iopcb_cb_cfg_t [1:5]         cb_cfg_in,
  input  wire logic                                   link_en_in,
  // Core output path of the wide port
  input  wire logic                                   out_valid_in,
  output logic                                        out_ready_out,
  input  wire iopcb_pkg::iopcb_out_word_t             out_word_in,
  // Core input path, timestamps and counter of the wide port
  output logic                                        in_valid_out,
  input  wire logic                                   in_take_in,
  output logic [iopcb_pkg::WIDE_WIDTH-1:0]            in_data_out,
  output logic [iopcb_pkg::COUNT_WIDTH-1:0]           in_stamp_out,
  output logic [iopcb_pkg::COUNT_WIDTH-1:0]           out_stamp_out,
  output logic [iopcb_pkg::COUNT_WIDTH-1:0]           count_out,
  // Narrow port core access
  input  wire logic                                   narrow_data_in,
  output logic                                        narrow_value_out,
  // Strobes
  input  wire logic                                   strobe_in,
  output logic                                        strobe_out,
  // Pins
  input  wire logic [iopcb_pkg::BANK_PINS-1:0]        pin_in,
  output logic [iopcb_pkg::BANK_PINS-1:0]             pin_out,
  output logic [iopcb_pkg::BANK_PINS-1:0]             pin_oe_out,
  output logic [iopcb_pkg::BANK_PINS-1:0]             pull_down_out
);

  // Output and enable for one pin from port direction and mode
  function automatic logic [1:0] pin_drive(input logic drive, input logic oc, input logic val);
    logic [1:0] r;
    r = 2'b00;
    if (drive && oc) begin
      r = {!val, 1'b0};
    end else if (drive) begin
      r = {1'b1, val};
    end
    return r;
  endfunction : pin_drive

  // Sampling condition test
  function automatic logic cond_met(input iopcb_pkg::iopcb_cond_t c,
                                    input logic [iopcb_pkg::WIDE_WIDTH-1:0] v,
                                    input logic [iopcb_pkg::WIDE_WIDTH-1:0] ref_v);
    logic ok;
    ok = 1'b1;
    case (c)
      iopcb_pkg::IOPCB_COND_EQ: ok = (v == ref_v);
      iopcb_pkg::IOPCB_COND_NE: ok = (v != ref_v);
      default:                  ok = 1'b1;
    endcase
    return ok;
  endfunction : cond_met

  logic [iopcb_pkg::NUM_CB-1:0]         cb_tick;
  logic                                 src_prev_q;
  logic                                 src_rise;
  logic [iopcb_pkg::COUNT_WIDTH-1:0]    count_q;
  logic                                 port_tick;
  logic                                 narrow_tick;
  logic                                 buf_valid;
  logic                                 buf_pop;
  iopcb_pkg::iopcb_out_word_t           buf_word;
  logic [iopcb_pkg::WIDE_WIDTH-1:0]     wide_val_q;
  logic                                 narrow_val_q;
  logic [iopcb_pkg::WIDE_WIDTH-1:0]     wide_sample;
  logic                                 sample_ok;
  logic                                 in_valid_q;
  logic [iopcb_pkg::WIDE_WIDTH-1:0]     in_data_q;
  logic [iopcb_pkg::COUNT_WIDTH-1:0]    in_stamp_q;
  logic [iopcb_pkg::COUNT_WIDTH-1:0]    out_stamp_q;
  logic [iopcb_pkg::COUNT_WIDTH-1:0]    count_rd_q;
  logic                                 narrow_rd_q;
  logic                                 strobe_q;
  logic [iopcb_pkg::BANK_PINS-1:0]      pin_q;
  logic [iopcb_pkg::BANK_PINS-1:0]      pin_oe_q;
  logic [iopcb_pkg::BANK_PINS-1:0]      pull_q;
  logic [iopcb_pkg::CB_SEL_WIDTH-1:0]   wide_sel_q;
  logic [iopcb_pkg::CB_SEL_WIDTH-1:0]   narrow_sel_q;
  logic                                 strobe_pend_q;

  // Clock blocks
  assign cb_tick[0] = 1'b1;
  assign src_rise   = pin_in[iopcb_pkg::CLK_SRC_PIN] && !src_prev_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_prev_q <= 1'b0;
    end else if (clk_en_in) begin
      src_prev_q <= pin_in[iopcb_pkg::CLK_SRC_PIN];
    end
  end

  genvar gk;
  generate
    for (gk = 1; gk < iopcb_pkg::NUM_CB; gk++) begin : g_cb
      logic [iopcb_pkg::DIV_WIDTH-1:0] div_cnt_q;
      logic                            src_edge;
      assign src_edge    = cb_cfg_in[gk].from_pin ? src_rise : 1'b1;
      assign cb_tick[gk] = src_edge && (div_cnt_q == cb_cfg_in[gk].divide);

      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          div_cnt_q <= iopcb_pkg::DIV_RESET;
        end else if (clk_en_in && src_edge) begin
          if (div_cnt_q >= cb_cfg_in[gk].divide) begin
            div_cnt_q <= iopcb_pkg::DIV_RESET;
          end else begin
            div_cnt_q <= div_cnt_q + iopcb_pkg::DIV_STEP;
          end
        end
      end
    end
  endgenerate

  // Clock block attachment, block 0 out of reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wide_sel_q   <= iopcb_pkg::CB_REF;
      narrow_sel_q <= iopcb_pkg::CB_REF;
    end else if (clk_en_in) begin
      wide_sel_q   <= wide_cfg_in.clk_sel;
      narrow_sel_q <= narrow_cfg_in.clk_sel;
    end
  end

  // Out-of-range selection gives no tick
  assign port_tick   = (wide_sel_q < iopcb_pkg::NUM_CB) && cb_tick[wide_sel_q];
  assign narrow_tick = (narrow_sel_q < iopcb_pkg::NUM_CB) && cb_tick[narrow_sel_q];

  // Port counter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= iopcb_pkg::COUNT_RESET;
    end else if (clk_en_in && port_tick) begin
      count_q <= count_q + iopcb_pkg::COUNT_STEP;
    end
  end

  // Output buffer in front of the transfer register
  iopcb_buf2 #(
    .WIDTH (iopcb_pkg::OUT_WORD_BITS)
  ) u_out_buf (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .clk_en_in   (clk_en_in),
    .s_valid_in  (out_valid_in),
    .s_ready_out (out_ready_out),
    .s_data_in   (out_word_in),
    .m_valid_out (buf_valid),
    .m_ready_in  (buf_pop),
    .m_data_out  (buf_word)
  );

  // Pop only when the port drives and the scheduled count is reached
  assign buf_pop = buf_valid && port_tick && wide_cfg_in.enable && wide_cfg_in.drive
                   && (!buf_word.timed || (buf_word.when == count_q));

  // Wide port value register, held between transfers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wide_val_q  <= '0;
      out_stamp_q <= iopcb_pkg::COUNT_RESET;
    end else if (clk_en_in && buf_pop) begin
      wide_val_q  <= buf_word.data;
      out_stamp_q <= count_q;
    end
  end

  // Output strobe in the cycle the popped word reaches the pins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strobe_pend_q <= 1'b0;
      strobe_q      <= 1'b0;
    end else if (clk_en_in) begin
      strobe_pend_q <= buf_pop;
      strobe_q      <= strobe_pend_q && wide_cfg_in.strobe_out_en;
    end
  end

  // Input sampling, always the full port width
  assign wide_sample = pin_in;
  assign sample_ok   = wide_cfg_in.enable && !wide_cfg_in.drive && port_tick
                       && (!wide_cfg_in.strobe_in_en || strobe_in)
                       && cond_met(wide_cfg_in.cond, wide_sample, wide_cfg_in.cond_value)
                       && (!in_valid_q || in_take_in);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_valid_q <= 1'b0;
      in_data_q  <= '0;
      in_stamp_q <= iopcb_pkg::COUNT_RESET;
    end else if (clk_en_in) begin
      if (sample_ok) begin
        in_valid_q <= 1'b1;
        in_data_q  <= wide_sample;
        in_stamp_q <= count_q;
      end else if (in_take_in) begin
        in_valid_q <= 1'b0;
      end
    end
  end

  // Narrow port: drives its value or samples the pin on its own ticks
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      narrow_val_q <= 1'b0;
      narrow_rd_q  <= 1'b0;
    end else if (clk_en_in && narrow_tick && narrow_cfg_in.enable) begin
      if (narrow_cfg_in.drive) begin
        narrow_val_q <= narrow_data_in;
      end else begin
        narrow_rd_q <= pin_in[iopcb_pkg::NARROW_PIN];
      end
    end
  end

  // Counter snapshot for the core
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_rd_q <= iopcb_pkg::COUNT_RESET;
    end else if (clk_en_in) begin
      count_rd_q <= count_q;
    end
  end

  // Pin ownership: link, then narrow port, then wide port
  genvar gp;
  generate
    for (gp = 0; gp < iopcb_pkg::BANK_PINS; gp++) begin : g_pin
      logic [1:0] drv;
      always_comb begin
        drv = 2'b00;
        if (link_en_in && gp >= iopcb_pkg::LINK_LO_PIN && gp <= iopcb_pkg::LINK_HI_PIN) begin
          drv = 2'b00;
        end else if (narrow_cfg_in.enable && gp == iopcb_pkg::NARROW_PIN) begin
          drv = pin_drive(narrow_cfg_in.drive, narrow_cfg_in.open_col, narrow_val_q);
        end else if (wide_cfg_in.enable) begin
          drv = pin_drive(wide_cfg_in.drive, wide_cfg_in.open_col, wide_val_q[gp]);
        end
      end

      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pin_oe_q[gp] <= 1'b0;
          pin_q[gp]    <= 1'b0;
        end else if (clk_en_in) begin
          pin_oe_q[gp] <= drv[1];
          pin_q[gp]    <= drv[0];
        end
      end
    end
  endgenerate

  // Pull-downs on while reset is held, off from the first enabled edge after release
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pull_q <= iopcb_pkg::PULL_ALL_ON;
    end else if (clk_en_in) begin
      pull_q <= iopcb_pkg::PULL_ALL_OFF;
    end
  end

  assign in_valid_out     = in_valid_q;
  assign in_data_out      = in_data_q;
  assign in_stamp_out     = in_stamp_q;
  assign out_stamp_out    = out_stamp_q;
  assign count_out        = count_rd_q;
  assign narrow_value_out = narrow_rd_q;
  assign strobe_out       = strobe_q;
  assign pin_out          = pin_q;
  assign pin_oe_out       = pin_oe_q;
  assign pull_down_out    = pull_q;

endmodule : iopcb_port_bank
